// ### include/usb_out_ep_pkg.sv
package usb_out_ep_pkg;

    // register index on the plain port (8-bit data)
    localparam logic [2:0] ADDR_CTRL_LOW   = 3'h0;   // out_endpoint_control_low
    localparam logic [2:0] ADDR_CTRL_HIGH  = 3'h1;   // double buffer / iso mode
    localparam logic [2:0] ADDR_COUNT_LOW  = 3'h2;   // out_count_low_byte
    localparam logic [2:0] ADDR_COUNT_HIGH = 3'h3;   // out_count_high_bits
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;   // sticky event bits
    localparam logic [2:0] ADDR_IRQ_MASK   = 3'h5;   // interrupt mask

    // control low field positions
    localparam int BIT_FLUSH   = 4;
    localparam int BIT_RECEIVE_DATA_ERROR_FLAG  = 3;
    localparam int BIT_RECEIVE_OVERRUN_FLAG   = 2;
    localparam int BIT_FULL    = 1;
    localparam int BIT_PKTRDY  = 0;
    // control high field positions
    localparam int BIT_DBUF    = 7;
    localparam int BIT_ISO     = 6;
    // interrupt status field positions
    localparam int IRQ_PKT     = 0;
    localparam int IRQ_OVR     = 1;
    localparam int IRQ_FLUSHED = 2;

    localparam int COUNT_W     = 10;                 // packet byte count width
    localparam logic [7:0] RESET_BYTE = 8'h00;       // every register resets to zero
    localparam logic [1:0] SLOT_MAX   = 2'h2;        // two packet slots at most

    // packet arrival from the receive engine
    typedef struct packed {
        logic                 valid;    // one-cycle pulse: packet completed
        logic                 crc_err;  // crc or bit-stuffing error seen
        logic [COUNT_W-1:0]   count;    // bytes in the packet
    } rx_pkt_s;

    // firmware register access
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

endpackage : usb_out_ep_pkg

// ### rtl/usb_sticky_bit.sv
// one sticky event bit: hardware set wins over software write-one clear
module usb_sticky_bit (
    input  wire logic CLK_SYS,    // system clock
    input  wire logic RSTN,       // sync reset, active low
    input  wire logic set,        // event pulse
    input  wire logic clr,        // clear request
    output logic      q           // sticky state
);
    typedef struct packed {
        logic q;
    } st_s;

    st_s st;
    st_s next_st;

    // set has priority so an event in the clear cycle is kept
    always_comb begin
        next_st = st;
        if (clr) begin
            next_st.q = 1'b0;
        end
        if (set) begin
            next_st.q = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;
endmodule : usb_sticky_bit

// ### rtl/usb_slot_count.sv
// remembers byte count and error mark of up to two buffered packets
module usb_slot_count
    import usb_out_ep_pkg::*;
(
    input  wire logic               CLK_SYS,   // system clock
    input  wire logic               RSTN,      // sync reset, active low
    input  wire logic               push,      // store a packet
    input  wire logic               pop,       // drop the oldest packet
    input  wire logic [COUNT_W-1:0] in_count,  // count of stored packet
    input  wire logic               in_err,    // data error of stored packet
    output logic [1:0]              used,      // packets held
    output logic [COUNT_W-1:0]      head_count,// count of oldest packet
    output logic                    head_err   // error of oldest packet
);
    typedef struct packed {
        logic [1:0]             used;
        logic [1:0][COUNT_W-1:0] cnt;
        logic [1:0]             err;
    } st_s;

    st_s st;
    st_s next_st;

    // pop shifts slot 1 down; push writes the first free slot after the pop
    always_comb begin
        logic [1:0] u;
        u       = st.used;
        next_st = st;
        if (pop && u != 2'h0) begin
            next_st.cnt[0] = st.cnt[1];
            next_st.err[0] = st.err[1];
            u              = u - 2'h1;
        end
        if (push && u < SLOT_MAX) begin
            next_st.cnt[u[0]] = in_count;
            next_st.err[u[0]] = in_err;
            u                 = u + 2'h1;
        end
        next_st.used = u;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign used       = st.used;
    assign head_count = st.cnt[0];
    assign head_err   = st.err[0];
endmodule : usb_slot_count

// ### rtl/usb_out_endpoint_status.sv
module usb_out_endpoint_status
    import usb_out_ep_pkg::*;
(
    input  wire logic               CLK_SYS,     // system clock, 50 MHz
    input  wire logic               RSTN,        // sync reset, active low
    input  wire logic [2:0]         ADDR,        // register index
    input  wire logic [7:0]         WDATA,       // write data
    input  wire logic               WR,          // write strobe
    input  wire logic               RD,          // read strobe
    output logic      [7:0]         RDATA,       // read data, cycle after RD
    input  wire logic               RX_VALID,    // packet received pulse
    input  wire logic               RX_CRC_ERR,  // packet had crc/stuff error
    input  wire logic [COUNT_W-1:0] RX_COUNT,    // bytes in received packet
    output logic                    RX_ACCEPT,   // packet stored this cycle
    output logic                    FLUSH_POP,   // pulse: one packet discarded
    output logic                    IRQ          // interrupt, level
);
    typedef struct packed {
        logic       flush;     // flush pending
        logic       pktrdy;    // packet ready flag
        logic       receive_overrun_flag;     // overrun flag
        logic       dbuf;      // double buffer enable
        logic       iso;       // isochronous mode
        logic [2:0] mask;      // interrupt mask
        logic [7:0] rdata;     // registered read data
        logic       pop_q;     // flush discard done last cycle
    } st_s;

    st_s st;
    st_s next_st;

    // pins gathered into the package carriers
    rx_pkt_s  rx;
    reg_req_s req;
    assign rx  = '{valid: RX_VALID, crc_err: RX_CRC_ERR, count: RX_COUNT};
    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    logic [1:0]         used;        // packets held
    logic [COUNT_W-1:0] head_count;  // count of oldest packet
    logic               head_err;    // error mark of oldest packet
    logic               full;        // fifo full
    logic               push;        // store incoming packet
    logic               pop;         // drop oldest packet
    logic               fw_unload;   // firmware clears ready
    logic               flush_pop;   // flush discards one packet
    logic               overflow;    // packet lost to full fifo
    logic [2:0]         irq_status;  // sticky events
    logic [2:0]         irq_clr;     // write-one clear

    logic wr_low;
    logic wr_high;
    assign wr_low  = req.wr && req.addr == ADDR_CTRL_LOW;
    assign wr_high = req.wr && req.addr == ADDR_CTRL_HIGH;

    assign full = st.dbuf ? (used == SLOT_MAX) : (used != 2'h0);

    // only the slots the mode allows are used; overflow drops the packet
    assign push     = rx.valid && !full;
    assign overflow = rx.valid && full;

    // firmware unload: write zero to ready while ready is set
    // firmware clears ready
    // a flush write is never also an unload, or one write would drop two packets
    assign fw_unload = wr_low && !req.wdata[BIT_PKTRDY] && !req.wdata[BIT_FLUSH]
                       && st.pktrdy && !st.flush;

    // one packet per flush
    // flush acts one cycle after the write, exactly once, then self-clears
    assign flush_pop = st.flush && used != 2'h0;
    assign pop       = fw_unload || flush_pop;
    assign FLUSH_POP = st.pop_q;

    usb_slot_count u_slots (
        .CLK_SYS    (CLK_SYS),
        .RSTN       (RSTN),
        .push       (push),
        .pop        (pop),
        .in_count   (rx.count),
        .in_err     (rx.crc_err),
        .used       (used),
        .head_count (head_count),
        .head_err   (head_err)
    );

    // next state of control and flags
    always_comb begin
        next_st       = st;
        next_st.pop_q = flush_pop;
        if (st.flush) begin
            next_st.flush = 1'b0;
        end
        if (wr_low) begin
            // a fresh flush request is taken only when none is pending
            if (req.wdata[BIT_FLUSH] && !st.flush) begin
                next_st.flush = 1'b1;
            end
            // software clears overrun by writing zero
            if (!req.wdata[BIT_RECEIVE_OVERRUN_FLAG]) begin
                next_st.receive_overrun_flag = 1'b0;
            end
        end
        if (wr_high) begin
            next_st.dbuf = req.wdata[BIT_DBUF];
            next_st.iso  = req.wdata[BIT_ISO];
        end
        if (req.wr && req.addr == ADDR_IRQ_MASK) begin
            next_st.mask = req.wdata[2:0];
        end
        // second packet re-raises ready
        // ready is recomputed after pops: it rises again if a packet remains
        next_st.pktrdy = (used != 2'h0 && !pop) || (pop && used == SLOT_MAX) || push;
        if (flush_pop) begin
            // a packet stored in the same cycle keeps ready up
            next_st.pktrdy = (used == SLOT_MAX) || push;
        end
        if (overflow && st.iso) begin
            next_st.receive_overrun_flag = 1'b1;
        end
        // registered read data, valid the cycle after the strobe
        next_st.rdata = RESET_BYTE;
        if (req.rd) begin
            unique case (req.addr)
                ADDR_CTRL_LOW: begin
                    next_st.rdata[BIT_FLUSH]  = st.flush;
                    next_st.rdata[BIT_RECEIVE_DATA_ERROR_FLAG] = st.iso && st.pktrdy && head_err;
                    next_st.rdata[BIT_RECEIVE_OVERRUN_FLAG]  = st.receive_overrun_flag;
                    next_st.rdata[BIT_FULL]   = full;
                    next_st.rdata[BIT_PKTRDY] = st.pktrdy;
                end
                ADDR_CTRL_HIGH: begin
                    next_st.rdata[BIT_DBUF] = st.dbuf;
                    next_st.rdata[BIT_ISO]  = st.iso;
                end
                ADDR_COUNT_LOW:  next_st.rdata = st.pktrdy ? head_count[7:0] : RESET_BYTE;
                ADDR_COUNT_HIGH: next_st.rdata = {6'h00, st.pktrdy ? head_count[9:8] : 2'h0};
                ADDR_IRQ_STATUS: next_st.rdata = {5'h00, irq_status};
                ADDR_IRQ_MASK:   next_st.rdata = {5'h00, st.mask};
                default:         next_st.rdata = RESET_BYTE;   // unmapped reads zero
            endcase
        end
    end

    // state register; synchronous reset clears every flag and the mode bits
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // interrupt events: ready rising (incl. second packet), overrun, flush done
    logic pkt_event;
    assign pkt_event = next_st.pktrdy && (!st.pktrdy || pop);
    assign irq_clr   = (req.wr && req.addr == ADDR_IRQ_STATUS) ? req.wdata[2:0] : 3'h0;

    // second interrupt
    // packet event: ready rising, including the re-raise for a second packet
    usb_sticky_bit u_irq_pkt (
        .CLK_SYS (CLK_SYS),
        .RSTN    (RSTN),
        .set     (pkt_event),
        .clr     (irq_clr[IRQ_PKT]),
        .q       (irq_status[IRQ_PKT])
    );
    // overrun event fires in any mode; only the flag is limited to iso
    usb_sticky_bit u_irq_ovr (
        .CLK_SYS (CLK_SYS),
        .RSTN    (RSTN),
        .set     (overflow),
        .clr     (irq_clr[IRQ_OVR]),
        .q       (irq_status[IRQ_OVR])
    );
    // flush done event, one per discarded packet
    usb_sticky_bit u_irq_fl (
        .CLK_SYS (CLK_SYS),
        .RSTN    (RSTN),
        .set     (flush_pop),
        .clr     (irq_clr[IRQ_FLUSHED]),
        .q       (irq_status[IRQ_FLUSHED])
    );

    assign IRQ       = |(irq_status & st.mask);
    assign RDATA     = st.rdata;
    assign RX_ACCEPT = push;

    // assertions: each guards one rule of the design side, checked every edge
    // flush self-clears
    property p_flush_done;
        @(posedge CLK_SYS) disable iff (!RSTN) st.flush |=> !st.flush;
    endproperty
    a_flush_done: assert property (p_flush_done)
        else $error("flush bit did not clear");

    property p_flush_one;
        @(posedge CLK_SYS) disable iff (!RSTN)
            (flush_pop && !push) |=> (used == $past(used) - 2'h1);
    endproperty
    a_flush_one: assert property (p_flush_one)
        else $error("flush dropped wrong count");

    property p_flush_rdy;
        @(posedge CLK_SYS) disable iff (!RSTN)
            (flush_pop && used == 2'h1 && !push) |=> !st.pktrdy;
    endproperty
    a_flush_rdy: assert property (p_flush_rdy)
        else $error("ready kept after flush");

    // second packet fills double buffer
    // the mode must not change in that cycle, or the depth moves under the check
    property p_full_dbl;
        @(posedge CLK_SYS) disable iff (!RSTN)
            (st.dbuf && !wr_high && used == 2'h1 && rx.valid && !pop)
            |=> (used == 2'h2) && full;
    endproperty
    a_full_dbl: assert property (p_full_dbl)
        else $error("double buffer not full at two");

    // single buffer refuses a second packet
    property p_full_sgl;
        @(posedge CLK_SYS) disable iff (!RSTN)
            (!st.dbuf && !wr_high && used == 2'h1 && rx.valid && !pop)
            |=> (used == 2'h1) && full;
    endproperty
    a_full_sgl: assert property (p_full_sgl)
        else $error("single buffer took a second packet");

    property p_ovr;
        @(posedge CLK_SYS) disable iff (!RSTN) (rx.valid && full && st.iso) |=> st.receive_overrun_flag;
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("overrun not set");

    property p_rdy_set;
        @(posedge CLK_SYS) disable iff (!RSTN) push |=> st.pktrdy;
    endproperty
    a_rdy_set: assert property (p_rdy_set)
        else $error("ready not set on packet");

    property p_second;
        @(posedge CLK_SYS) disable iff (!RSTN)
            (fw_unload && used == 2'h2) |=> st.pktrdy && irq_status[IRQ_PKT];
    endproperty
    a_second: assert property (p_second)
        else $error("second packet not flagged");

    property p_ovr_irq;
        @(posedge CLK_SYS) disable iff (!RSTN) overflow |=> irq_status[IRQ_OVR];
    endproperty
    a_ovr_irq: assert property (p_ovr_irq)
        else $error("overrun event lost");

    property p_count;
        @(posedge CLK_SYS) disable iff (!RSTN)
            (push && used == 2'h0)
            |=> (head_count == $past(rx.count)) && (head_err == $past(rx.crc_err));
    endproperty
    a_count: assert property (p_count)
        else $error("packet count or error mark not kept");

    // overrun flag stays clear outside iso
    property p_iso_gate;
        @(posedge CLK_SYS) disable iff (!RSTN) (!st.iso && !st.receive_overrun_flag) |=> !st.receive_overrun_flag;
    endproperty
    a_iso_gate: assert property (p_iso_gate)
        else $error("overrun flag set outside iso");

    // main scenarios: two held, flush, iso overrun, second packet re-raise
    c_second: cover property (@(posedge CLK_SYS) disable iff (!RSTN) fw_unload && used == 2'h2);
    c_two:   cover property (@(posedge CLK_SYS) disable iff (!RSTN) used == 2'h2);
    c_flush: cover property (@(posedge CLK_SYS) disable iff (!RSTN) flush_pop);
    c_ovr:   cover property (@(posedge CLK_SYS) disable iff (!RSTN) overflow && st.iso);
endmodule : usb_out_endpoint_status

// ### sim/usb_host_model.sv
// far side: a host whose receive engine hands finished packets to the block
module usb_host_model
    import usb_out_ep_pkg::*;
(
    input  wire logic               clk,      // system clock
    input  wire logic               accept,   // packet stored by the block
    output logic                    valid,    // packet done pulse
    output logic                    crc_err,  // packet error mark
    output logic [COUNT_W-1:0]      count,    // packet byte count
    output logic                    accepted  // accept seen on last packet
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        valid    = 1'b0;
        crc_err  = 1'b0;
        count    = '0;
        accepted = 1'b0;
    end

    // one packet: pulse for one cycle, then scramble the qualifiers
    // packet arrival
    task automatic send(input logic [COUNT_W-1:0] cnt, input logic err);
        @(posedge clk);
        valid   <= 1'b1;
        crc_err <= err;
        count   <= cnt;
        // accept is combinational, look once the edge has settled
        #1 accepted = accept;
        @(posedge clk);
        valid   <= 1'b0;
        // stale qualifiers must not be relied on
        crc_err <= ~err;
        count   <= ~cnt;
    endtask : send
endmodule : usb_host_model

// ### sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import usb_out_ep_pkg::*;

    logic               clk_sys;     // 50 MHz clock
    logic               rstn;        // sync reset
    logic [2:0]         addr;        // register index
    logic [7:0]         wdata;       // write data
    logic               wr;          // write strobe
    logic               rd;          // read strobe
    logic [7:0]         rdata;       // read data
    logic               rx_valid;    // packet pulse
    logic               rx_crc_err;  // packet error
    logic [COUNT_W-1:0] rx_count;    // packet count
    logic               rx_accept;   // packet stored
    logic               flush_pop;   // discard pulse
    logic               irq;         // interrupt level
    logic               acc;         // host saw accept
    int                 mismatches;  // failed checks
    int                 n_tests;     // checks made
    int                 pops;        // discard pulses seen
    int                 cycles;      // watchdog count

    usb_out_endpoint_status u_dut (
        .CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .RX_VALID(rx_valid), .RX_CRC_ERR(rx_crc_err), .RX_COUNT(rx_count),
        .RX_ACCEPT(rx_accept), .FLUSH_POP(flush_pop), .IRQ(irq)
    );
    usb_host_model u_host (
        .clk(clk_sys), .accept(rx_accept), .valid(rx_valid), .crc_err(rx_crc_err),
        .count(rx_count), .accepted(acc)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // discard pulses and watchdog; a hang counts as a mismatch
    always @(posedge clk_sys) begin
        if (flush_pop === 1'b1) pops <= pops + 1;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one-cycle write; the gap before the next strobe comes from the next edge wait
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask : rd_chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    // every register at zero, unmapped place reads zero
    task automatic t_reset();
        for (int i = 0; i < 7; i++) rd_chk(3'(i), 8'h00, "reset value");
        $display("test reset done");
    endtask : t_reset

    // single buffering, bulk mode
    task automatic t_single();
        wr_reg(ADDR_IRQ_MASK, 8'h01);
        u_host.send(10'h2A5, 1'b0);
        rd_chk(ADDR_CTRL_LOW, 8'h03, "ready and full");
        rd_chk(ADDR_COUNT_LOW, 8'hA5, "count low");
        rd_chk(ADDR_COUNT_HIGH, 8'h02, "count high");
        chk("irq", 8'h01, {7'h00, irq});
        u_host.send(10'h011, 1'b0);
        chk("accept when full", 8'h00, {7'h00, acc});
        rd_chk(ADDR_CTRL_LOW, 8'h03, "no overrun in bulk");
        rd_chk(ADDR_IRQ_STATUS, 8'h03, "status");
        wr_reg(ADDR_IRQ_STATUS, 8'h03);
        // status clears at the write's edge: look once that edge has settled
        #1 chk("irq cleared", 8'h00, {7'h00, irq});
        wr_reg(ADDR_CTRL_LOW, 8'h00);
        rd_chk(ADDR_CTRL_LOW, 8'h00, "unloaded");
        $display("test single done");
    endtask : t_single

    // double buffering, iso mode, unload and flush
    task automatic t_double();
        int p0;
        wr_reg(ADDR_CTRL_HIGH, 8'hC0);
        wr_reg(3'h7, 8'hFF);
        rd_chk(ADDR_IRQ_MASK, 8'h01, "unmapped write ignored");
        rd_chk(ADDR_CTRL_HIGH, 8'hC0, "mode bits");
        wr_reg(ADDR_IRQ_MASK, 8'h02);
        u_host.send(10'h005, 1'b1);
        u_host.send(10'h007, 1'b0);
        rd_chk(ADDR_CTRL_LOW, 8'h0B, "two packets, error");
        u_host.send(10'h009, 1'b0);
        chk("accept when full", 8'h00, {7'h00, acc});
        rd_chk(ADDR_CTRL_LOW, 8'h0F, "overrun");
        chk("overrun irq", 8'h01, {7'h00, irq});
        wr_reg(ADDR_IRQ_STATUS, 8'h07);
        // unload first packet, keep overrun
        wr_reg(ADDR_CTRL_LOW, 8'h04);
        rd_chk(ADDR_CTRL_LOW, 8'h05, "second ready");
        rd_chk(ADDR_COUNT_LOW, 8'h07, "second count");
        rd_chk(ADDR_IRQ_STATUS, 8'h01, "second event");
        p0 = pops;
        // the second packet's count was read above; now that packet is flushed
        wr_reg(ADDR_CTRL_LOW, 8'h10);
        repeat (3) @(posedge clk_sys);
        rd_chk(ADDR_CTRL_LOW, 8'h00, "flushed");
        chk("pop pulses", 8'h01, 8'(pops - p0));
        rd_chk(ADDR_IRQ_STATUS, 8'h05, "flush event");
        wr_reg(ADDR_IRQ_STATUS, 8'h07);
        u_host.send(10'h003, 1'b0);
        u_host.send(10'h004, 1'b0);
        wr_reg(ADDR_CTRL_LOW, 8'h10);
        repeat (3) @(posedge clk_sys);
        rd_chk(ADDR_CTRL_LOW, 8'h01, "one flushed");
        rd_chk(ADDR_COUNT_LOW, 8'h04, "remaining count");
        wr_reg(ADDR_CTRL_LOW, 8'h10);
        repeat (3) @(posedge clk_sys);
        rd_chk(ADDR_CTRL_LOW, 8'h00, "both flushed");
        chk("pop pulses", 8'h03, 8'(pops - p0));
        $display("test double done");
    endtask : t_double

    initial begin
        rstn       = 1'b0;
        addr       = 3'h0;
        wdata      = 8'h00;
        wr         = 1'b0;
        rd         = 1'b0;
        mismatches = 0;
        n_tests    = 0;
        pops       = 0;
        cycles     = 0;
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_single();
        t_double();
        conclude();
    end
endmodule : testbench
